// ==== src/iop_debounce.sv ====
`timescale 1ns/100ps
`default_nettype none

module iop_debounce
    import iop_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    iop_filt_if.filt  fl
);

    typedef struct packed {
        logic [15:0] sample;
        logic [15:0] stable;
    } iop_deb_state_t;

    iop_deb_state_t st;
    iop_deb_state_t next_st;

    // Level must agree on two filter ticks, so pulses under
    // one tick period never reach the output.
    always_comb
    begin
        next_st = st;
        if (fl.tick)
        begin
            next_st.sample = fl.raw;
            next_st.stable = (fl.raw & ~(fl.raw ^ st.sample)) | (st.stable & (fl.raw ^ st.sample));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign fl.stable = st.stable;

endmodule : iop_debounce

`default_nettype wire

// ==== src/iop_filt_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface iop_filt_if;
    logic [15:0] raw;
    logic        tick;
    logic [15:0] stable;

    modport core (output raw, output tick, input stable);
    modport filt (input raw, input tick, output stable);
endinterface : iop_filt_if

`default_nettype wire

// ==== src/iop_pkg.sv ====
package iop_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int unsigned NGRP   = 5;       // Groups 0..3 and the debug group
    localparam int unsigned NPIN   = 8;       // Pin numbers 0..7 in each group
    localparam int unsigned NALL   = 40;
    localparam int unsigned GRP_D  = 4;
    localparam int unsigned NFILT  = 16;      // Groups 0 and 1 only

    // Pins that exist and carry the general-purpose function
    localparam logic [39:0] GPIO_MASK  = 40'h1f_ff_ff_ff_7f;
    // Same set without the output-only debug-group pin 2
    localparam logic [39:0] INPUT_MASK = 40'h1b_ff_ff_ff_7f;
    // Pins with the anti-bounce filter
    localparam logic [15:0] FILT_MASK  = 16'hff_7f;
    // Pins that may feed the edge interrupt logic
    localparam logic [39:0] INT_MASK   = 40'h00_ff_ff_ff_7f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [39:0] SEL_RST    = 40'h07_00_00_00_00;  // Debug group pins 0..2 start on peripheral path
    localparam logic [79:0] MUX_RST    = 80'h0;               // Function 0 is the debug signal
    localparam logic [1:0]  CLKSRC_RST = 2'h0;
    localparam logic [3:0]  CLKDIV_RST = 4'h0;
    localparam logic [15:0] PROT_RST   = 16'h0000;
    localparam logic [15:0] PROT_KEY   = 16'h0096;

    // ------------------------------------------------------------
    // Register map, word addresses
    // ------------------------------------------------------------
    localparam int unsigned AW         = 7;
    localparam logic [2:0]  REG_DATA   = 3'h0;   // [7:0] out, [15:8] in (read only)
    localparam logic [2:0]  REG_IOEN   = 3'h1;   // [7:0] output en, [15:8] input en
    localparam logic [2:0]  REG_PULL   = 3'h2;   // [7:0] pull en, [15:8] 1=up 0=down
    localparam logic [2:0]  REG_MODSEL = 3'h3;   // [7:0] peripheral enable
    localparam logic [2:0]  REG_FNCSEL = 3'h4;   // [2y+1:2y] function selector
    localparam logic [2:0]  REG_CHATEN = 3'h5;   // [7:0] filter enable
    localparam logic [6:0]  ADDR_PCLK  = 7'h40;  // [1:0] src, [7:4] div, [8] debug run
    localparam logic [6:0]  ADDR_PROT  = 7'h41;
    localparam int unsigned PCLK_DIV_LSB = 4;
    localparam int unsigned PCLK_DEBUG_RUN_ENABLE   = 8;

endpackage : iop_pkg

// ==== src/iop_port_unit.sv ====
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - After reset non-debug pins: no input, no output, no pulls, Hi-Z, GPIO.
// - Reset configuration holds until software writes new settings.
// - Debug-shared pins come up on the debug signal path.
// - Each pin selects GPIO or one of four peripheral functions.
// - Pins addressed by group and pin number zero to seven.
// - Per-pin pull-up or pull-down choice, and per-pin pull disable.
// - GPIO pins drive high or low, or float in high impedance.
// - Anti-bounce filter works only while the filter clock is supplied.
// - Filter clock from two-bit source and four-bit divider fields.
// - Source stopping in sleep disables filtering during sleep.
// - Debug run clear suspends the filter clock in debug mode.
// - Suspended clock stops filtering, blocks filtered input, registers stay writable.
// - Debug run set keeps filter clock and filtering going in debug.
// - Only groups zero and one have the anti-bounce filter.
// - Edge interrupt sources only from groups zero to three.
// - Debug group pin two is output only, with no input path.
// - Output data bit drives the pin, one high, zero low.
// - Input data bit shows sampled pin level, one high.
// - Filter on a pin active only when its filter enable is one.
module iop_port_unit
    import iop_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    // Register port
    input  wire logic [6:0]    addr,
    input  wire logic [15:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [15:0]   rdata,
    // Pins, flat: bit 8*group+pin
    input  wire logic [39:0]   pin_in,
    output logic      [39:0]   pin_out,
    output logic      [39:0]   pin_oe,
    output logic      [39:0]   pin_input_enable,
    output logic      [39:0]   pin_pull_up,
    output logic      [39:0]   pin_pull_down,
    // Peripheral side
    input  wire logic [39:0]   periph_out,
    input  wire logic [39:0]   periph_oe,
    output logic      [39:0]   periph_in,
    output logic      [39:0]   peripheral_enable,
    output logic      [79:0]   peripheral_function_selector,
    // Clock generator and system state
    input  wire logic [3:0]    source_tick,
    input  wire logic [3:0]    source_sleep_stop,
    input  wire logic          sleep_mode,
    input  wire logic          debug_mode,
    output logic               filter_clock,
    // Toward the edge interrupt logic
    output logic      [39:0]   edge_source
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [39:0] output_data_bit;
        logic [39:0] pin_output_enable;
        logic [39:0] pin_input_enable;
        logic [39:0] pull_en;
        logic [39:0] pull_up_sel;
        logic [39:0] peripheral_enable;
        logic [79:0] peripheral_function_selector;
        logic [15:0] debounce_enable;
        logic [1:0]  filter_clock_source;
        logic [3:0]  filter_clock_divider;
        logic        debug_run_enable;
        logic [15:0] protect_key;
        logic [15:0] div_count;
        logic        filter_tick;
        logic [39:0] input_data_bit;
        logic [15:0] rdata;
    } iop_state_t;

    iop_state_t st;
    iop_state_t next_st;

    iop_filt_if filt_bus ();

    iop_debounce u_debounce (
        .mclk (mclk),
        .rst  (rst),
        .fl   (filt_bus.filt)
    );

    // ------------------------------------------------------------
    // Filter clock supply
    // ------------------------------------------------------------
    logic        src_stops;
    logic        sleep_stopped;
    logic        debug_held;
    logic        clock_supplied;
    logic        src_tick;
    logic [15:0] div_limit;

    always_comb
    begin
        src_stops      = source_sleep_stop[st.filter_clock_source];
        sleep_stopped  = sleep_mode & src_stops;
        debug_held     = debug_mode & ~st.debug_run_enable;
        clock_supplied = ~sleep_stopped & ~debug_held;
        src_tick       = source_tick[st.filter_clock_source] & clock_supplied;
        div_limit      = (16'h1 << st.filter_clock_divider) - 16'h1;
    end

    assign filter_clock  = st.filter_tick;
    assign filt_bus.tick = st.filter_tick;
    assign filt_bus.raw  = pin_in[15:0] & FILT_MASK;

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    logic [15:0] filt_on;
    logic [39:0] in_path;

    always_comb
    begin
        filt_on = st.debounce_enable & FILT_MASK;
        in_path = pin_in;
        for (int i = 0; i < NFILT; i++)
        begin
            if (filt_on[i])
            begin
                if (clock_supplied)
                    in_path[i] = filt_bus.stable[i];
                else if (sleep_stopped)
                    in_path[i] = pin_in[i];
                else
                    in_path[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NALL; i++)
        begin
            if (st.peripheral_enable[i])
            begin
                // Peripheral owns the pad, pulls are switched off
                pin_out[i]          = periph_out[i];
                pin_oe[i]           = periph_oe[i];
                pin_input_enable[i] = INPUT_MASK[i];
                pin_pull_up[i]      = 1'b0;
                pin_pull_down[i]    = 1'b0;
            end
            else
            begin
                pin_out[i]          = st.output_data_bit[i];
                pin_oe[i]           = st.pin_output_enable[i];
                pin_input_enable[i] = st.pin_input_enable[i];
                // Pulls drop out whenever the output drives
                pin_pull_up[i]      = st.pull_en[i] & st.pull_up_sel[i] & ~st.pin_output_enable[i];
                pin_pull_down[i]    = st.pull_en[i] & ~st.pull_up_sel[i] & ~st.pin_output_enable[i];
            end
        end
    end

    assign periph_in                    = pin_in & st.peripheral_enable & INPUT_MASK;
    assign peripheral_enable            = st.peripheral_enable;
    assign peripheral_function_selector = st.peripheral_function_selector;
    assign edge_source                  = st.input_data_bit & ~st.peripheral_enable & INT_MASK;
    assign rdata                        = st.rdata;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [2:0] grp;
    logic [2:0] sub;
    logic       grp_hit;
    logic       unlocked;

    always_comb
    begin
        grp      = addr[5:3];
        sub      = addr[2:0];
        grp_hit  = ~addr[6] & (grp < 3'(NGRP));
        unlocked = (st.protect_key == PROT_KEY);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [5:0]  b;
        logic [7:0]  gm;
        logic [15:0] rv;
        next_st = st;
        b       = 6'(grp) << 3;
        gm      = GPIO_MASK[b +: 8];
        rv      = 16'h0;

        // Divider runs only on ticks of the selected live source
        next_st.filter_tick = 1'b0;
        if (src_tick)
        begin
            if (st.div_count >= div_limit)
            begin
                next_st.div_count   = 16'h0;
                next_st.filter_tick = 1'b1;
            end
            else
            begin
                next_st.div_count = st.div_count + 16'h1;
            end
        end

        // Sampled every cycle, so a read sees the level one clock old
        next_st.input_data_bit = in_path & st.pin_input_enable & ~st.peripheral_enable & INPUT_MASK;

        // Writes are accepted whatever the filter clock is doing
        if (wr & grp_hit)
        begin
            unique case (sub)
                REG_DATA:
                    next_st.output_data_bit[b +: 8] = wdata[7:0] & gm;
                REG_IOEN:
                begin
                    next_st.pin_output_enable[b +: 8] = wdata[7:0] & gm;
                    next_st.pin_input_enable[b +: 8]  = wdata[15:8] & INPUT_MASK[b +: 8];
                end
                REG_PULL:
                begin
                    next_st.pull_en[b +: 8]     = wdata[7:0] & gm;
                    next_st.pull_up_sel[b +: 8] = wdata[15:8] & gm;
                end
                REG_MODSEL:
                    next_st.peripheral_enable[b +: 8] = wdata[7:0] & gm;
                REG_FNCSEL:
                    next_st.peripheral_function_selector[7'(grp) * 7'd16 +: 16] = wdata;
                REG_CHATEN:
                begin
                    if (grp == 3'h0)
                        next_st.debounce_enable[7:0] = wdata[7:0] & FILT_MASK[7:0];
                    else if (grp == 3'h1)
                        next_st.debounce_enable[15:8] = wdata[7:0] & FILT_MASK[15:8];
                end
                default:
                begin
                end
            endcase
        end
        else if (wr & (addr == ADDR_PCLK) & unlocked)
        begin
            next_st.filter_clock_source  = wdata[1:0];
            next_st.filter_clock_divider = wdata[PCLK_DIV_LSB +: 4];
            next_st.debug_run_enable     = wdata[PCLK_DEBUG_RUN_ENABLE];
        end
        else if (wr & (addr == ADDR_PROT))
        begin
            next_st.protect_key = wdata;
        end

        // Read data stand in the cycle after the strobe only
        if (rd & grp_hit)
        begin
            unique case (sub)
                REG_DATA:
                    rv = {st.input_data_bit[b +: 8], st.output_data_bit[b +: 8]};
                REG_IOEN:
                    rv = {st.pin_input_enable[b +: 8], st.pin_output_enable[b +: 8]};
                REG_PULL:
                    rv = {st.pull_up_sel[b +: 8], st.pull_en[b +: 8]};
                REG_MODSEL:
                    rv = {8'h0, st.peripheral_enable[b +: 8]};
                REG_FNCSEL:
                    rv = st.peripheral_function_selector[7'(grp) * 7'd16 +: 16];
                REG_CHATEN:
                begin
                    if (grp == 3'h0)
                        rv = {8'h0, st.debounce_enable[7:0]};
                    else if (grp == 3'h1)
                        rv = {8'h0, st.debounce_enable[15:8]};
                end
                default:
                    rv = 16'h0;
            endcase
        end
        else if (rd & (addr == ADDR_PCLK))
        begin
            rv = {7'h0, st.debug_run_enable, st.filter_clock_divider, 2'h0, st.filter_clock_source};
        end
        else if (rd & (addr == ADDR_PROT))
        begin
            rv = {15'h0, unlocked};
        end
        next_st.rdata = rv;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st                              <= '0;
            st.peripheral_enable            <= SEL_RST;
            st.peripheral_function_selector <= MUX_RST;
            st.filter_clock_source          <= CLKSRC_RST;
            st.filter_clock_divider         <= CLKDIV_RST;
            st.protect_key                  <= PROT_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : iop_port_unit

`default_nettype wire

// ==== tb/iop_pin_world.sv ====
`timescale 1ns/100ps
`default_nettype none

module iop_pin_world
(
    input  wire logic        mclk,
    input  wire logic [39:0] pin_out,
    input  wire logic [39:0] pin_oe,
    input  wire logic [39:0] pin_pull_up,
    input  wire logic [39:0] pin_pull_down,
    input  wire logic [39:0] ext_en,
    input  wire logic [39:0] ext_val,
    output logic      [39:0] pin_in,
    output logic      [39:0] periph_out
);
    logic [39:0] drift = 40'h55_5555_5555;

    // Floating lines wander, so a released pin never looks like a level
    always @(posedge mclk)
        drift <= ~drift;

    assign periph_out = drift ^ 40'h0f_0f0f_0f0f;
    assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                      | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & drift)));
endmodule : iop_pin_world

`default_nettype wire

// ==== tb/iop_port_unit_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none

module iop_port_unit_monitor
    import iop_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [6:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic [39:0] pin_in,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pin_input_enable,
    input wire logic [39:0] pin_pull_up,
    input wire logic [39:0] pin_pull_down,
    input wire logic [39:0] periph_out,
    input wire logic [39:0] periph_oe,
    input wire logic [39:0] periph_in,
    input wire logic [39:0] peripheral_enable,
    input wire logic [79:0] peripheral_function_selector,
    input wire logic [3:0]  source_tick,
    input wire logic        sleep_mode,
    input wire logic        debug_mode,
    input wire logic        filter_clock,
    input wire logic [39:0] edge_source
);
    // --------
    // Shadow of the protected clock setup
    // --------
    logic [15:0] prot_q;
    logic [1:0]  src_q;
    logic [3:0]  div_q;
    logic        dbr_q;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            prot_q <= PROT_RST;
            src_q  <= CLKSRC_RST;
            div_q  <= CLKDIV_RST;
            dbr_q  <= 1'b0;
        end
        else if (wr && addr == ADDR_PROT)
            prot_q <= wdata;
        else if (wr && addr == ADDR_PCLK && prot_q == PROT_KEY)
        begin
            src_q <= wdata[1:0];
            div_q <= wdata[7:4];
            dbr_q <= wdata[PCLK_DEBUG_RUN_ENABLE];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_reset_state:
    assert property ($past(rst) |-> (pin_input_enable & ~SEL_RST) == 40'h0 && (pin_pull_up | pin_pull_down) == 40'h0
        && peripheral_enable == SEL_RST && peripheral_function_selector == MUX_RST && (pin_oe & ~SEL_RST) == 40'h0)
        else $error("pin state after reset wrong");
    chk_periph_path:
    assert property ((((pin_out ^ periph_out) | (pin_oe ^ periph_oe)) & peripheral_enable) == 40'h0
        && ((periph_in ^ pin_in) & peripheral_enable & INPUT_MASK) == 40'h0)
        else $error("peripheral path not routed");
    chk_missing_pins:
    assert property (((pin_out | pin_oe | pin_input_enable | pin_pull_up | peripheral_enable) & ~GPIO_MASK) == 40'h0)
        else $error("nonexistent pin active");
    chk_pull_excl:
    assert property (((pin_pull_up & pin_pull_down) | ((pin_pull_up | pin_pull_down) & pin_oe)) == 40'h0)
        else $error("pull conflict");
    chk_out_only:
    assert property (!pin_input_enable[34] && !edge_source[34])
        else $error("output-only pin has input");
    chk_edge_groups:
    assert property (edge_source[39:32] == 8'h00)
        else $error("debug group feeds interrupts");
    chk_rdata_idle:
    assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_tick_nodiv:
    assert property (source_tick[src_q] && div_q == 4'h0 && !debug_mode && !sleep_mode |=> filter_clock)
        else $error("filter tick missing");
    chk_debug_stop:
    assert property (debug_mode && $past(debug_mode) && !dbr_q |=> !filter_clock)
        else $error("filter clock runs in debug");
endmodule : iop_port_unit_monitor

bind iop_port_unit iop_port_unit_monitor u_mon (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out,
    .pin_oe, .pin_input_enable, .pin_pull_up, .pin_pull_down, .periph_out, .periph_oe, .periph_in,
    .peripheral_enable, .peripheral_function_selector, .source_tick, .sleep_mode, .debug_mode, .filter_clock,
    .edge_source);

`default_nettype wire

// ==== tb/iop_port_unit_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module iop_port_unit_tb
    import iop_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  addr = 7'h0;
    logic [15:0] wdata = 16'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [39:0] pin_in, pin_out, pin_oe, pin_ie, pin_pu, pin_pd, per_out, per_in, per_en, edge_src;
    logic [39:0] per_oe = 40'h0, ext_en = 40'h0, ext_val = 40'h0;
    logic [79:0] per_sel;
    logic [3:0]  tick = 4'h0, slp_stop = 4'h0;
    logic        sleep = 1'b0, dbg = 1'b0, fclk;
    int          bad_count = 0, samples_checked = 0, fc_cnt = 0;

    always #5 mclk = ~mclk;

    always @(posedge mclk)
        if (fclk === 1'b1)
            fc_cnt <= fc_cnt + 1;

    iop_port_unit dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_enable(pin_ie), .pin_pull_up(pin_pu),
        .pin_pull_down(pin_pd), .periph_out(per_out), .periph_oe(per_oe), .periph_in(per_in),
        .peripheral_enable(per_en), .peripheral_function_selector(per_sel), .source_tick(tick),
        .source_sleep_stop(slp_stop), .sleep_mode(sleep), .debug_mode(dbg), .filter_clock(fclk),
        .edge_source(edge_src));

    iop_pin_world u_world (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pu),
        .pin_pull_down(pin_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in), .periph_out(per_out));

    // --------
    // Bus and check tasks
    // --------
    function automatic logic [6:0] ga(input int g, input logic [2:0] r);
        return {1'b0, g[2:0], r};
    endfunction : ga

    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rchk(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {24'h0, rdata & m}, {24'h0, e});
    endtask : rchk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_cyc

    // Protected setup, relocked straight after
    task automatic setclk(input logic [15:0] d);
        wr_reg(ADDR_PROT, PROT_KEY);
        wr_reg(ADDR_PCLK, d);
        wr_reg(ADDR_PROT, 16'h0000);
    endtask : setclk

    task automatic fcnt(input int n, input int e);
        fc_cnt = 0;
        repeat (n)
        begin
            @(posedge mclk);
            tick <= 4'h2;
            @(posedge mclk);
            tick <= 4'h0;
        end
        wait_cyc(3);
        chk("filter ticks", 40'(fc_cnt), 40'(e));
    endtask : fcnt

    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        close_out();
    end

    // --------
    // Scenarios
    // --------
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (2)
        begin
            for (int g = 0; g < 5; g++)
                for (int r = 1; r < 6; r++)
                    rchk(ga(g, r[2:0]), (g == 4 && r == 3) ? 16'h0007 : 16'h0000);
            wait_cyc(20);
        end
        rchk(7'h06, 16'h0000);
        wr_reg(ga(0, REG_IOEN), 16'h00ff);
        wr_reg(ga(0, REG_MODSEL), 16'h0000);
        wr_reg(ga(0, REG_DATA), 16'h00a5);
        wait_cyc(2);
        chk("gpio out", pin_out & 40'hff, 40'h25);
        chk("gpio oe", pin_oe & 40'hff, 40'h7f);
        wr_reg(ga(0, REG_IOEN), 16'h0000);
        ext_en  <= 40'h0000_f003;
        ext_val <= 40'h0000_c003;
        wr_reg(ga(1, REG_PULL), 16'h050f);
        wr_reg(ga(1, REG_IOEN), 16'hff00);
        wait_cyc(2);
        chk("hi-z", pin_oe & 40'hff, 40'h0);
        chk("pull up", pin_pu, 40'h0500);
        chk("pull down", pin_pd, 40'h0a00);
        rchk(ga(1, REG_DATA), 16'hc500);
        chk("edge source", edge_src, 40'h00_0000_c500);
        chk("input enable", pin_ie, 40'h03_0000_ff00);
        wr_reg(ga(4, REG_IOEN), 16'hff00);
        rchk(ga(4, REG_IOEN), 16'h1b00);
        wr_reg(ga(2, REG_CHATEN), 16'h00ff);
        rchk(ga(2, REG_CHATEN), 16'h0000);
        wr_reg(ga(2, REG_IOEN), 16'h0000);
        wr_reg(ga(2, REG_MODSEL), 16'h0000);
        wr_reg(ga(2, REG_FNCSEL), 16'h00e4);
        wr_reg(ga(2, REG_MODSEL), 16'h000f);
        per_oe <= 40'h000f_0000;
        wait_cyc(2);
        chk("func sel", {32'h0, per_sel[39:32]}, 40'he4);
        chk("periph en", per_en, 40'h07_000f_0000);
        chk("periph oe", pin_oe & 40'hff_0000, 40'h0f_0000);
        wr_reg(ADDR_PCLK, 16'h0011);
        rchk(ADDR_PCLK, 16'h0000);
        wr_reg(ADDR_PROT, PROT_KEY);
        rchk(ADDR_PROT, 16'h0001);
        wr_reg(ADDR_PCLK, 16'h0001);
        wr_reg(ADDR_PROT, 16'h0000);
        rchk(ADDR_PCLK, 16'h0001);
        fcnt(8, 8);
        setclk(16'h0021);
        fcnt(8, 2);
        setclk(16'h0001);
        wr_reg(ga(0, REG_CHATEN), 16'h0001);
        wr_reg(ga(0, REG_IOEN), 16'h0300);
        fcnt(4, 4);
        rchk(ga(0, REG_DATA), 16'h0300, 16'h0300);
        @(posedge mclk);
        dbg <= 1'b1;
        fcnt(8, 0);
        rchk(ga(0, REG_DATA), 16'h0200, 16'h0300);
        wr_reg(ga(0, REG_DATA), 16'h0000);
        rchk(ga(0, REG_DATA), 16'h0000, 16'h00ff);
        @(posedge mclk);
        dbg <= 1'b0;
        fcnt(8, 8);
        setclk(16'h0101);
        @(posedge mclk);
        dbg <= 1'b1;
        fcnt(8, 8);
        rchk(ga(0, REG_DATA), 16'h0100, 16'h0100);
        @(posedge mclk);
        dbg     <= 1'b0;
        ext_val <= 40'h0;
        wait_cyc(4);
        rchk(ga(0, REG_DATA), 16'h0100, 16'h0300);
        fcnt(4, 4);
        rchk(ga(0, REG_DATA), 16'h0000, 16'h0300);
        @(posedge mclk);
        ext_val  <= 40'h3;
        sleep    <= 1'b1;
        slp_stop <= 4'h2;
        wait_cyc(3);
        rchk(ga(0, REG_DATA), 16'h0300, 16'h0300);
        fcnt(4, 0);
        close_out();
    end
endmodule : iop_port_unit_tb

`default_nettype wire
